// [shared/tcam_cfg.svh]
`ifndef TCAM_CFG_SVH
`define TCAM_CFG_SVH
`define TCAM_ADDR_CTRL      32'h0000_0000
`define TCAM_ADDR_STATUS    32'h0000_0004
`define TCAM_ADDR_STRAPS    32'h0000_0008
`define TCAM_CTRL_MEM_EN    0
`define TCAM_CTRL_PWRDN     1
`define TCAM_CTRL_RESET     32'h0000_0000
`define TCAM_SYNC_STAGES    2
`define TCAM_STRAP_DELAY_NS 100
`define TCAM_CLK_NS         20
`define TCAM_STRAP_CYCLES   ((`TCAM_STRAP_DELAY_NS + `TCAM_CLK_NS - 1) / `TCAM_CLK_NS)
`endif

// [shared/tcam_pkg.sv]
package tcam_pkg;
    typedef enum logic [1:0] {
        STRAP_WAIT,
        STRAP_TAKE,
        STRAP_DONE
    } tcam_strap_type;
    typedef logic [1:0] tcam_port_type;
endpackage

// [verilog/tcam_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tcam_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [verilog/tcam_mode_select.sv]
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tcam_cfg.svh"
module tcam_mode_select (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hsel,
    input  wire logic                  hready,
    input  wire logic [31:0]           hwdata,
    output var  logic [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  typec_control_mode_select,
    input  wire logic                  attach_polarity_select,
    input  wire tcam_pkg::tcam_port_type port_attach_in,
    input  wire tcam_pkg::tcam_port_type port_orientation_in,
    input  wire tcam_pkg::tcam_port_type mode2_attach_line_a,
    input  wire tcam_pkg::tcam_port_type mode2_attach_line_b,
    input  wire logic [3:0]            mem_data_in,
    output var  logic [3:0]            mem_lane_data,
    output logic                       mem_chip_enable_n_out,
    output logic                       mem_chip_enable_n_oe,
    output var  logic                  battery_charge_enable_strap,
    output var  tcam_pkg::tcam_port_type phy_power_on,
    output var  tcam_pkg::tcam_port_type phy_a_enable,
    output var  tcam_pkg::tcam_port_type phy_b_enable,
    output var  logic                  control_mode2_active
);
    import tcam_pkg::*;

    localparam int NSYNC = 10;

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_in;
    logic             mode_s;
    logic             pol_s;
    tcam_port_type    att_s;
    tcam_port_type    ori_s;
    tcam_port_type    mxa_s;
    tcam_port_type    mxb_s;
    tcam_port_type    attach_act;
    tcam_port_type    orient_act;
    logic [31:0]      ctrl_q;
    logic             wr_pend_q;
    logic             rd_pend_q;
    logic [31:0]      addr_q;
    logic             mem_en;
    logic             pwrdn;
    tcam_strap_type   strap_state_q;
    logic [7:0]       strap_cnt_q;
    logic [31:0]      rd_word;
    logic             addr_phase;

    // Selected inputs become active high for the rest of the logic
    function automatic tcam_port_type to_active(input tcam_port_type v, input logic pol);
        to_active = pol ? ~v : v;
    endfunction

    assign raw_in = {typec_control_mode_select, attach_polarity_select, port_attach_in,
                     port_orientation_in, mode2_attach_line_a, mode2_attach_line_b};

    // Two flops per input; only the second stage is used
    tcam_sync #(.W(NSYNC)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (raw_in),
        .q       (sync_in)
    );

    // A reset value of zero gives mode 1 and active high until inputs settle
    assign {mode_s, pol_s, att_s, ori_s, mxa_s, mxb_s} = sync_in;

    always_comb begin
        if (mode_s) begin
            attach_act = to_active(mxa_s, pol_s);
            orient_act = to_active(mxb_s, pol_s);
        end else begin
            attach_act = to_active(att_s, pol_s);
            orient_act = to_active(ori_s, pol_s);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_power_on         <= '0;
            phy_a_enable         <= '0;
            phy_b_enable         <= '0;
            control_mode2_active <= 1'b0;
        end else begin
            phy_power_on         <= attach_act;
            phy_a_enable         <= attach_act & ~orient_act;
            phy_b_enable         <= attach_act & orient_act;
            control_mode2_active <= mode_s;
        end
    end

    assign mem_en = ctrl_q[`TCAM_CTRL_MEM_EN];
    assign pwrdn  = ctrl_q[`TCAM_CTRL_PWRDN];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_lane_data <= '0;
        end else if (mem_en) begin
            mem_lane_data <= mem_data_in;
        end
    end

    // Chip enable is driven high in powerdown with memory enabled so the memory cannot wake
    assign mem_chip_enable_n_out = 1'b1;
    assign mem_chip_enable_n_oe  = mem_en & pwrdn;

    // Strap is taken once, a settle time after reset, and only without memory
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_state_q               <= STRAP_WAIT;
            strap_cnt_q                 <= '0;
            battery_charge_enable_strap <= 1'b0;
        end else begin
            case (strap_state_q)
                STRAP_WAIT: begin
                    if (strap_cnt_q == 8'(`TCAM_STRAP_CYCLES - 1)) begin
                        strap_state_q <= STRAP_TAKE;
                    end else begin
                        strap_cnt_q <= strap_cnt_q + 8'h01;
                    end
                end
                STRAP_TAKE: begin
                    if (!mem_en) begin
                        battery_charge_enable_strap <= mem_data_in[0];
                    end
                    strap_state_q <= STRAP_DONE;
                end
                STRAP_DONE: strap_state_q <= STRAP_DONE;
                default:    strap_state_q <= STRAP_WAIT;
            endcase
        end
    end

    assign addr_phase = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
        end else if (hready) begin
            wr_pend_q <= addr_phase & hwrite;
            rd_pend_q <= addr_phase & ~hwrite;
            addr_q    <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `TCAM_CTRL_RESET;
        end else if (wr_pend_q && addr_q == `TCAM_ADDR_CTRL) begin
            ctrl_q <= {30'h0000_0000, hwdata[1:0]};
        end
    end

    always_comb begin
        case (haddr)
            `TCAM_ADDR_CTRL:   rd_word = ctrl_q;
            `TCAM_ADDR_STATUS: rd_word = {23'h00_0000, control_mode2_active, phy_b_enable,
                                          phy_a_enable, phy_power_on, pol_s, mode_s};
            `TCAM_ADDR_STRAPS: rd_word = {31'h0000_0000, battery_charge_enable_strap};
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_phase && !hwrite) begin
            hrdata <= rd_word;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    bus_zero_wait_a : assert property (@(posedge hclk) disable iff (!hresetn) hreadyout && !hresp);
    phy_power_a : assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> phy_power_on == $past(attach_act));
    phy_exclusive_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (phy_a_enable & phy_b_enable) == 2'b00 && (phy_a_enable | phy_b_enable) == phy_power_on);
    mode1_path_a : assert property (@(posedge hclk) disable iff (!hresetn)
        !mode_s && !pol_s |-> attach_act == att_s && orient_act == ori_s);
    mode2_path_a : assert property (@(posedge hclk) disable iff (!hresetn)
        mode_s && !pol_s |-> attach_act == mxa_s && orient_act == mxb_s);
    low_polarity_a : assert property (@(posedge hclk) disable iff (!hresetn)
        pol_s && !mode_s |-> attach_act == ~att_s);
    input_sync_a : assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ##1 sync_in == $past(raw_in, 2));
    lane_capture_a : assert property (@(posedge hclk) disable iff (!hresetn)
        mem_en |=> mem_lane_data == $past(mem_data_in));
    chip_idle_a : assert property (@(posedge hclk) disable iff (!hresetn)
        mem_en && pwrdn |-> mem_chip_enable_n_oe && mem_chip_enable_n_out);
    strap_take_a : assert property (@(posedge hclk) disable iff (!hresetn)
        strap_state_q == STRAP_TAKE && !mem_en |=> battery_charge_enable_strap == $past(mem_data_in[0]));
    default_mode_a : assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> !control_mode2_active);
    // Read data is the word decoded in the address phase; a control write lands one edge later
    read_data_a : assert property (@(posedge hclk) disable iff (!hresetn)
        addr_phase && !hwrite |=> rd_pend_q && hrdata == $past(rd_word));
    ctrl_write_a : assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && addr_q == `TCAM_ADDR_CTRL |=> ctrl_q == ($past(hwdata) & 32'h0000_0003));
    lane_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
        !mem_en |=> $stable(mem_lane_data));
    strap_once_a : assert property (@(posedge hclk) disable iff (!hresetn)
        strap_state_q == STRAP_DONE |=> $stable(battery_charge_enable_strap));
    orient_invert_a : assert property (@(posedge hclk) disable iff (!hresetn)
        pol_s && !mode_s |-> orient_act == ~ori_s);
    mode2_invert_a : assert property (@(posedge hclk) disable iff (!hresetn)
        pol_s && mode_s |-> attach_act == ~mxa_s && orient_act == ~mxb_s);
endmodule
`default_nettype wire

// [bench/tcam_typec_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// Port controller side: logical attach and orientation become pin levels
module tcam_typec_partner (
    input  wire logic       pol,
    input  wire logic       mode,
    input  wire logic [1:0] att,
    input  wire logic [1:0] ori,
    output logic [1:0]      m1_att,
    output logic [1:0]      m1_ori,
    output logic [1:0]      m2_att,
    output logic [1:0]      m2_ori
);
    logic [1:0] att_pin;
    logic [1:0] ori_pin;
    assign att_pin = att ^ {2{pol}};
    assign ori_pin = ori ^ {2{pol}};
    // The unused pin set carries the inverse so that a wrong mode choice shows up
    assign m1_att = mode ? ~att_pin : att_pin;
    assign m1_ori = mode ? ~ori_pin : ori_pin;
    assign m2_att = mode ? att_pin : ~att_pin;
    assign m2_ori = mode ? ori_pin : ~ori_pin;
endmodule
`default_nettype wire

// [bench/typec_attach_mode_select_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tcam_cfg.svh"
module typec_attach_mode_select_bench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        mode = 1'b0;
    logic        pol = 1'b0;
    logic [1:0]  att = 2'b00;
    logic [1:0]  ori = 2'b00;
    logic [1:0]  m1_att, m1_ori, m2_att, m2_ori;
    logic [3:0]  mem_in = 4'h1;
    logic [3:0]  lanes;
    logic        ce_out, ce_oe, strap, mode2;
    logic [1:0]  pwr, pa, pb;
    logic [31:0] rd;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #10 hclk = ~hclk;
    tcam_typec_partner far (.pol(pol), .mode(mode), .att(att), .ori(ori),
        .m1_att(m1_att), .m1_ori(m1_ori), .m2_att(m2_att), .m2_ori(m2_ori));
    tcam_mode_select dut (.hclk(hclk), .hresetn(hresetn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hsel(1'b1), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .typec_control_mode_select(mode),
        .attach_polarity_select(pol), .port_attach_in(m1_att), .port_orientation_in(m1_ori),
        .mode2_attach_line_a(m2_att), .mode2_attach_line_b(m2_ori), .mem_data_in(mem_in),
        .mem_lane_data(lanes), .mem_chip_enable_n_out(ce_out), .mem_chip_enable_n_oe(ce_oe),
        .battery_charge_enable_strap(strap), .phy_power_on(pwr), .phy_a_enable(pa),
        .phy_b_enable(pb), .control_mode2_active(mode2));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Entered just after a rising edge; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
        check({31'h0, strap}, 32'h0000_0001);
        mem_in <= 4'h0;
        xfer(1'b0, `TCAM_ADDR_STRAPS, 32'h0000_0000, rd);
        check(rd & 32'h0000_0001, 32'h0000_0001);
        xfer(1'b0, `TCAM_ADDR_CTRL, 32'h0000_0000, rd);
        check(rd, `TCAM_CTRL_RESET);
        check({30'h0, hreadyout, hresp}, 32'h0000_0002);
        xfer(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        for (int i = 0; i < 64; i++) begin
            mode <= i[5];
            pol  <= i[4];
            att  <= i[3:2];
            ori  <= i[1:0];
            repeat (5) @(posedge hclk);
            check({30'h0, pwr}, {30'h0, att});
            check({30'h0, pb}, {30'h0, att & ori});
            check({30'h0, pa}, {30'h0, att & ~ori});
            check({31'h0, mode2}, {31'h0, mode});
            xfer(1'b0, `TCAM_ADDR_STATUS, 32'h0000_0000, rd);
            check(rd, {23'h0, mode, att & ori, att & ~ori, att, pol, mode});
        end
        check({31'h0, strap}, 32'h0000_0001);
        xfer(1'b1, `TCAM_ADDR_CTRL, 32'h0000_0001, rd);
        mem_in <= 4'hA;
        repeat (3) @(posedge hclk);
        check({28'h0, lanes}, 32'h0000_000A);
        check({31'h0, ce_oe}, 32'h0000_0000);
        mem_in <= 4'h5;
        repeat (3) @(posedge hclk);
        check({28'h0, lanes}, 32'h0000_0005);
        xfer(1'b1, `TCAM_ADDR_CTRL, 32'h0000_0003, rd);
        repeat (2) @(posedge hclk);
        check({30'h0, ce_oe, ce_out}, 32'h0000_0003);
        xfer(1'b0, `TCAM_ADDR_CTRL, 32'h0000_0000, rd);
        check(rd, 32'h0000_0003);
        xfer(1'b1, `TCAM_ADDR_CTRL, 32'h0000_0000, rd);
        mem_in <= 4'hF;
        repeat (3) @(posedge hclk);
        check({27'h0, lanes, ce_oe}, 32'h0000_000A);
        stop_test();
    end
endmodule
`default_nettype wire
